// ==== common/ffpwm_pkg.sv ====
// Constants for the filtered fan PWM ramp controller: register indices,
// field positions, reset values and timing counts.
// Assumes a 100 MHz clock; byte address of a register is four times its index.
package ffpwm_pkg;
	localparam int CLK_HZ = 100_000_000;

	// Register indices (byte address = index * 4)
	localparam logic [5:0] IDX_CONFIG     = 6'h00;
	localparam logic [5:0] IDX_MIN_DUTY   = 6'h22;
	localparam logic [5:0] IDX_FILTER     = 6'h23;
	localparam logic [5:0] IDX_LOCAL      = 6'h24;
	localparam logic [5:0] IDX_REMOTE     = 6'h25;
	localparam logic [5:0] IDX_DUTY_STAT  = 6'h26;
	localparam logic [5:0] IDX_TARGET_STAT = 6'h27;

	// Reset values
	localparam logic [7:0] CONFIG_RST   = 8'h80;
	localparam logic [7:0] MIN_DUTY_RST = 8'h05;
	localparam logic [7:0] FILTER_RST   = 8'h10;
	localparam logic [7:0] LOCAL_RST    = 8'h43;
	localparam logic [7:0] REMOTE_RST   = 8'h63;

	// Field positions
	localparam int CFG_AUTO_BIT  = 7;
	localparam int CFG_SEL_LSB   = 5;
	localparam int FLT_SPIN_BIT  = 7;
	localparam int FLT_RAMP_LSB  = 5;
	localparam int FLT_RATE_LSB  = 2;
	localparam int FLT_EN_BIT    = 0;
	localparam int START_LSB     = 3;
	localparam int SPAN_LSB      = 0;
	localparam logic [1:0] SEL_REMOTE  = 2'h0;
	localparam logic [1:0] SEL_FASTEST = 2'h3;

	// Duty geometry
	localparam logic [7:0] SLOTS_PER_PERIOD = 8'hF0;
	localparam logic [2:0] SPAN_MAX_CODE    = 3'h4;
	localparam logic [2:0] RATE_MAX_CODE    = 3'h7;

	// Timing
	localparam int PWM_PERIOD_US     = 32000;
	localparam int SLOT_CYCLES_DEF   = PWM_PERIOD_US * (CLK_HZ / 1_000_000) / 240;
	localparam int UPDATE_FAST_MS    = 125;
	localparam int UPDATE_FAST_DEF   = UPDATE_FAST_MS * (CLK_HZ / 1000);
	localparam int SPINUP_MS         = 2000;
	localparam int SPINUP_CYCLES_DEF = SPINUP_MS * (CLK_HZ / 1000);

	typedef enum logic [1:0] {
		ST_OFF  = 2'b00,
		ST_SPIN = 2'b01,
		ST_RUN  = 2'b11
	} ffpwm_state_e;
endpackage

// ==== design/ffpwm_loop.sv ====
// One temperature channel of the automatic loop: temperature to duty in slots.
// Inputs come from the same clock domain; the result is registered.
`timescale 1ns/1ns
module ffpwm_loop
	import ffpwm_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [7:0] temp,
	input  wire logic [7:0] startSpan,
	input  wire logic [3:0] minCode,
	output logic [7:0]      duty
);
	logic [7:0]  startDeg;
	logic [2:0]  spanSh;
	logic [7:0]  diff;
	logic [12:0] incr;
	logic [12:0] sum;
	logic [7:0]  duty_d;

	// Start temperature in 4 degree steps, span 5 << code
	assign startDeg = {startSpan[7:START_LSB], 2'b00};
	assign spanSh   = (startSpan[2:0] > SPAN_MAX_CODE) ? SPAN_MAX_CODE : startSpan[2:0];
	assign diff     = temp - startDeg;

	// Ten codes of sixteen slots per span, so slots = diff * 32 / 2^code
	always_comb begin
		incr   = {diff, 5'b0_0000} >> spanSh;
		sum    = {5'h00, minCode, 4'h0} + incr;
		duty_d = 8'h00;
		if (temp < startDeg)
			duty_d = 8'h00;
		else if (sum > {5'h00, SLOTS_PER_PERIOD})
			duty_d = SLOTS_PER_PERIOD;
		else
			duty_d = sum[7:0];
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			duty <= 8'h00;
		else
			duty <= duty_d;
	end
endmodule

// ==== design/ffpwm_top.sv ====
// Filtered fan PWM ramp controller with an APB register slave.
// Temperatures arrive as whole degrees from another domain and are synchronised.
//
// Summary of operation
// - Local start temperature in bits 7:3, 4 degree steps, default 32 degrees.
// - Local span code in bits 2:0 selects 5, 10, 20, 40, 80 degrees.
// - Remote start temperature in bits 7:3 of its register, 4 degree steps.
// - Remote span code in bits 2:0 selects 5 to 80 degrees.
// - Unfiltered loop applies each new calculated duty at once.
// - Filter bit 0 enables filtered mode, reset to off.
// - Each PWM period holds 240 equal slots.
// - Filtered update steps previous duty toward new duty, stores result.
// - Ramp code bits 6:5 gives steps of 1, 2, 4 or 8 slots.
// - Sample rate code bits 4:2 gives 87.5 Hz doubling to 11.2 kHz; the code uses these bits only for the update tick rate.
// - Sample rate code resets to 100, 1.4 kHz; in the code 100 gives one update per second.
// - Filtered step runs once per update, 0.0625 to 8 per second.
// - Filter bit 7 set suppresses fan spin-up, reset to zero.
// - Config bit 7 selects automatic control, reset to one.
// - Config bits 6:5: 00 remote only, 11 fastest computed duty.
// - Minimum duty nibble in 16 codes, default 5.
// - Full duty reached at start plus (15 - min code) times span/10.
//
// Design decision made here: register access over APB.
`timescale 1ns/1ns
module ffpwm_top
	import ffpwm_pkg::*;
#(
	parameter int SLOT_CYCLES   = SLOT_CYCLES_DEF,
	parameter int UPDATE_FAST   = UPDATE_FAST_DEF,
	parameter int SPINUP_CYCLES = SPINUP_CYCLES_DEF
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [7:0]  tempLocal,
	input  wire logic [7:0]  tempRemote,
	output logic             pwmOut
);
	logic [7:0]   configQ;
	logic [7:0]   minDutyQ;
	logic [7:0]   filterQ;
	logic [7:0]   localQ;
	logic [7:0]   remoteQ;
	logic [7:0]   tLocS1Q, tLocS2Q;
	logic [7:0]   tRemS1Q, tRemS2Q;
	logic [7:0]   tLocS3Q, tRemS3Q;
	logic [7:0]   tLocQ, tRemQ;
	logic [7:0]   localDuty, remoteDuty;
	logic [7:0]   targetDuty;
	logic [7:0]   dutyQ;
	logic [7:0]   step;
	logic [31:0]  updCntQ;
	logic [31:0]  updLimit;
	logic         tick;
	logic [31:0]  slotDivQ;
	logic         slotTick;
	logic [7:0]   slotCntQ;
	logic [31:0]  spinCntQ;
	ffpwm_state_e stateQ;
	logic [7:0]   appliedDuty;
	logic         autoMode, filtEn, spinDis;
	logic [1:0]   chanSel;
	logic [5:0]   idx;
	logic         mapped, wrEn;

	assign autoMode = configQ[CFG_AUTO_BIT];
	assign chanSel  = configQ[CFG_SEL_LSB +: 2];
	assign filtEn   = filterQ[FLT_EN_BIT];
	assign spinDis  = filterQ[FLT_SPIN_BIT];
	assign idx      = paddr[7:2];

	// APB decode; slave answers with no wait state
	always_comb begin
		case (idx)
			IDX_CONFIG, IDX_MIN_DUTY, IDX_FILTER, IDX_LOCAL, IDX_REMOTE,
			IDX_DUTY_STAT, IDX_TARGET_STAT: mapped = 1'b1;
			default:                        mapped = 1'b0;
		endcase
	end
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign wrEn    = psel && penable && pwrite && mapped;

	// Register writes; is up to software, so settings apply whenever written
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			configQ  <= CONFIG_RST;
			minDutyQ <= MIN_DUTY_RST;
			filterQ  <= FILTER_RST;
			localQ   <= LOCAL_RST;
			remoteQ  <= REMOTE_RST;
		end else if (wrEn) begin
			case (idx)
				IDX_CONFIG:   configQ  <= pwdata[7:0];
				IDX_MIN_DUTY: minDutyQ <= {4'h0, pwdata[3:0]};
				IDX_FILTER:   filterQ  <= {pwdata[7:2], 1'b0, pwdata[0]};
				IDX_LOCAL:    localQ   <= pwdata[7:0];
				IDX_REMOTE:   remoteQ  <= pwdata[7:0];
				default:      ;
			endcase
		end
	end

	// Read data is captured in the setup cycle so it is a flop in the access cycle
	always_ff @(posedge clk) begin
		if (!rst_n)
			prdata <= 32'h0000_0000;
		else if (psel && !penable && !pwrite) begin
			case (idx)
				IDX_CONFIG:      prdata <= {24'h00_0000, configQ};
				IDX_MIN_DUTY:    prdata <= {24'h00_0000, minDutyQ};
				IDX_FILTER:      prdata <= {24'h00_0000, filterQ};
				IDX_LOCAL:       prdata <= {24'h00_0000, localQ};
				IDX_REMOTE:      prdata <= {24'h00_0000, remoteQ};
				IDX_DUTY_STAT:   prdata <= {24'h00_0000, appliedDuty};
				IDX_TARGET_STAT: prdata <= {24'h00_0000, targetDuty};
				default:         prdata <= 32'h0000_0000;
			endcase
		end
	end

	// Two-flop synchronisers; values change slowly against the update tick
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tLocS1Q <= 8'h00;
			tLocS2Q <= 8'h00;
			tRemS1Q <= 8'h00;
			tRemS2Q <= 8'h00;
		end else begin
			tLocS1Q <= tempLocal;
			tLocS2Q <= tLocS1Q;
			tRemS1Q <= tempRemote;
			tRemS2Q <= tRemS1Q;
		end
	end

	// Take a synchronised word only once it has held two cycles; a word caught mid-change is dropped
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tLocS3Q <= 8'h00;
			tRemS3Q <= 8'h00;
			tLocQ   <= 8'h00;
			tRemQ   <= 8'h00;
		end else begin
			tLocS3Q <= tLocS2Q;
			tRemS3Q <= tRemS2Q;
			if (tLocS2Q == tLocS3Q)
				tLocQ <= tLocS2Q;
			if (tRemS2Q == tRemS3Q)
				tRemQ <= tRemS2Q;
		end
	end

	ffpwm_loop u_local (
		.clk       (clk),
		.rst_n     (rst_n),
		.temp      (tLocQ),
		.startSpan (localQ),
		.minCode   (minDutyQ[3:0]),
		.duty      (localDuty)
	);

	ffpwm_loop u_remote (
		.clk       (clk),
		.rst_n     (rst_n),
		.temp      (tRemQ),
		.startSpan (remoteQ),
		.minCode   (minDutyQ[3:0]),
		.duty      (remoteDuty)
	);

	// Channel choice; codes 01 and 10 fall back to the local loop
	always_comb begin
		case (chanSel)
			SEL_REMOTE:  targetDuty = remoteDuty;
			SEL_FASTEST: targetDuty = (localDuty > remoteDuty) ? localDuty : remoteDuty;
			default:     targetDuty = localDuty;
		endcase
	end

	// Update tick: fastest rate is 8 per second, each lower code halves it
	assign updLimit = (32'(UPDATE_FAST) << (RATE_MAX_CODE - filterQ[FLT_RATE_LSB +: 3])) - 32'h1;
	assign tick     = (updCntQ >= updLimit);
	always_ff @(posedge clk) begin
		if (!rst_n || tick)
			updCntQ <= 32'h0000_0000;
		else
			updCntQ <= updCntQ + 32'h1;
	end

	// Ramp step of 1, 2, 4 or 8 slots
	assign step = 8'h01 << filterQ[FLT_RAMP_LSB +: 2];

	// Duty register: software value, immediate follow, or filtered ramp
	always_ff @(posedge clk) begin
		if (!rst_n)
			dutyQ <= 8'h00;
		else if (!autoMode)
			dutyQ <= {minDutyQ[3:0], 4'h0};
		else if (!filtEn)
			dutyQ <= targetDuty;
		else if (tick) begin
			if (targetDuty > dutyQ)
				dutyQ <= (dutyQ > SLOTS_PER_PERIOD - step) ? SLOTS_PER_PERIOD : dutyQ + step;
			else if (targetDuty < dutyQ)
				dutyQ <= (dutyQ < step) ? 8'h00 : dutyQ - step;
		end
	end

	// Spin-up: full drive for a while when the fan leaves the off state
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			stateQ   <= ST_OFF;
			spinCntQ <= 32'h0000_0000;
		end else begin
			case (stateQ)
				ST_OFF: begin
					if (dutyQ != 8'h00) begin
						stateQ   <= spinDis ? ST_RUN : ST_SPIN;
						spinCntQ <= 32'h0000_0000;
					end
				end
				ST_SPIN: begin
					spinCntQ <= spinCntQ + 32'h1;
					if (dutyQ == 8'h00)
						stateQ <= ST_OFF;
					else if (spinCntQ >= 32'(SPINUP_CYCLES) - 32'h1)
						stateQ <= ST_RUN;
				end
				ST_RUN: begin
					if (dutyQ == 8'h00)
						stateQ <= ST_OFF;
				end
				default: stateQ <= ST_OFF;
			endcase
		end
	end
	assign appliedDuty = (stateQ == ST_SPIN) ? SLOTS_PER_PERIOD : dutyQ;

	// Slot prescaler and free-running slot counter, 240 slots per period
	assign slotTick = (slotDivQ >= 32'(SLOT_CYCLES) - 32'h1);
	always_ff @(posedge clk) begin
		if (!rst_n || slotTick)
			slotDivQ <= 32'h0000_0000;
		else
			slotDivQ <= slotDivQ + 32'h1;
	end
	always_ff @(posedge clk) begin
		if (!rst_n)
			slotCntQ <= 8'h00;
		else if (slotTick)
			slotCntQ <= (slotCntQ == SLOTS_PER_PERIOD - 8'h01) ? 8'h00 : slotCntQ + 8'h01;
	end

	// PWM output is a flop; duty changes take effect at the next slot compare
	always_ff @(posedge clk) begin
		if (!rst_n)
			pwmOut <= 1'b0;
		else
			pwmOut <= (slotCntQ < appliedDuty);
	end

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_filter_reset;
		$rose(rst_n) |-> filterQ == FILTER_RST && configQ[CFG_AUTO_BIT];
	endproperty
	a_filter_reset: assert property (p_filter_reset) else $error("filter or config reset value wrong");

	property p_unfilt_follow;
		(autoMode && !filtEn && !wrEn) |=> dutyQ == $past(targetDuty);
	endproperty
	a_unfilt_follow: assert property (p_unfilt_follow) else $error("unfiltered duty not applied");

	sequence s_rise_req;
		tick && autoMode && filtEn && !wrEn && targetDuty > dutyQ && dutyQ <= SLOTS_PER_PERIOD - step;
	endsequence
	property p_ramp_up;
		s_rise_req |=> dutyQ == $past(dutyQ) + $past(step);
	endproperty
	a_ramp_up: assert property (p_ramp_up) else $error("ramp up step wrong");

	property p_ramp_down;
		(tick && autoMode && filtEn && !wrEn && targetDuty < dutyQ && dutyQ >= step)
			|=> dutyQ == $past(dutyQ) - $past(step);
	endproperty
	a_ramp_down: assert property (p_ramp_down) else $error("ramp down step wrong");

	property p_hold_equal;
		(autoMode && filtEn && !wrEn && (!tick || targetDuty == dutyQ)) |=> $stable(dutyQ);
	endproperty
	a_hold_equal: assert property (p_hold_equal) else $error("filtered duty moved without cause");

	property p_duty_cap;
		dutyQ <= SLOTS_PER_PERIOD && appliedDuty <= SLOTS_PER_PERIOD;
	endproperty
	a_duty_cap: assert property (p_duty_cap) else $error("duty above 240 slots");

	property p_slot_wrap;
		(slotTick && slotCntQ == SLOTS_PER_PERIOD - 8'h01) |=> slotCntQ == 8'h00;
	endproperty
	a_slot_wrap: assert property (p_slot_wrap) else $error("slot counter did not wrap at 240");

	property p_pwm_full;
		(appliedDuty == SLOTS_PER_PERIOD && $stable(appliedDuty)) |=> pwmOut;
	endproperty
	a_pwm_full: assert property (p_pwm_full) else $error("full duty but output low");

	property p_no_spin;
		(stateQ == ST_OFF && spinDis) |=> stateQ != ST_SPIN;
	endproperty
	a_no_spin: assert property (p_no_spin) else $error("spin-up despite disable");

	property p_fastest;
		chanSel == SEL_FASTEST |-> targetDuty >= localDuty && targetDuty >= remoteDuty;
	endproperty
	a_fastest: assert property (p_fastest) else $error("fastest channel not selected");

	property p_sw_duty;
		(!autoMode && !wrEn) |=> dutyQ == 8'($past(minDutyQ) << 4);
	endproperty
	a_sw_duty: assert property (p_sw_duty) else $error("software duty not applied");
endmodule

// ==== verification/ffpwm_fan.sv ====
// Cooling fan stand-in: measures the width and the period of the drive pulses.
// Assumes the drive is a registered signal in the clk domain.
`timescale 1ns/1ns
module ffpwm_fan (
	input  wire logic        clk,
	input  wire logic        pwm,
	output logic      [15:0] highLen,
	output logic      [15:0] periodLen
);
	logic [15:0] cntQ;
	logic [15:0] hiQ;
	logic        pwmQ;

	// Restart both counts at each rising edge; a steady level never reports
	always_ff @(posedge clk) begin
		pwmQ <= pwm;
		if (pwm && !pwmQ) begin
			periodLen <= cntQ;
			highLen   <= hiQ;
			cntQ      <= 16'h0001;
			hiQ       <= 16'h0001;
		end else begin
			cntQ <= cntQ + 16'h0001;
			hiQ  <= hiQ + {15'h0000, pwm};
		end
	end
endmodule

// ==== verification/ffpwm_top_tb.sv ====
// Self-checking bench for the fan PWM ramp controller over APB.
// Assumes short timing parameters: 2 clk a slot, tick base 4 clk, spin-up 8 clk.
`timescale 1ns/1ns
module ffpwm_top_tb import ffpwm_pkg::*;;
	logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, pwmOut, err;
	logic [7:0]  paddr, tempLocal, tempRemote;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] highLen, periodLen;
	int          numErrors, nChecks;
	// Rows: config, local, remote, local temp, remote temp, applied duty
	logic [7:0]  rows [12][6] = '{'{8'hE0, 8'h40, 8'hF8, 8'h21, 8'h00, 8'h70},
		'{8'hE0, 8'h01, 8'hF8, 8'h05, 8'h00, 8'hA0}, '{8'hE0, 8'h02, 8'hF8, 8'h05, 8'h00, 8'h78},
		'{8'hE0, 8'h03, 8'hF8, 8'h05, 8'h00, 8'h64}, '{8'hE0, 8'h04, 8'hF8, 8'h05, 8'h00, 8'h5A},
		'{8'hE0, 8'hF8, 8'hFC, 8'hC8, 8'h7C, 8'hF0}, '{8'h80, 8'hF8, 8'hFC, 8'hC8, 8'h7B, 8'h00},
		'{8'h80, 8'hF8, 8'hFC, 8'hC8, 8'h7C, 8'h50}, '{8'h00, 8'hF8, 8'hFC, 8'hC8, 8'h00, 8'h50},
		'{8'hE0, 8'h03, 8'hF8, 8'h27, 8'h00, 8'hEC}, '{8'hE0, 8'h03, 8'hF8, 8'h28, 8'h00, 8'hF0},
		'{8'hA0, 8'h03, 8'h00, 8'h27, 8'h05, 8'hEC}};

	ffpwm_top #(.SLOT_CYCLES(2), .UPDATE_FAST(4), .SPINUP_CYCLES(8)) ffpwm_top_i (.clk(clk), .rst_n(rst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .tempLocal(tempLocal), .tempRemote(tempRemote), .pwmOut(pwmOut));
	ffpwm_fan ffpwm_fan_i (.clk(clk), .pwm(pwmOut), .highLen(highLen), .periodLen(periodLen));

	// 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		nChecks++;
		if (got !== exp) begin
			numErrors++;
			$display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask

	task stop_test;
		if (numErrors == 0 && nChecks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// One APB transfer; request held until pready is seen high
	task xfer(input logic w, input logic [5:0] idx, input logic [7:0] d);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= {idx, 2'b00};
		pwdata  <= {24'h000000, d};
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input logic [5:0] idx, input logic [7:0] d);
		xfer(1'b1, idx, d);
	endtask

	task rdk(input logic [5:0] idx, input logic [31:0] exp);
		xfer(1'b0, idx, 8'h00);
		chk(rd, exp);
	endtask

	// Follow the applied duty to a goal; every change must be one step
	task climb(input int goal, input int step, input int tick);
		int v;
		int t;
		v = 240 - goal;
		t = $time / 10;
		while (v != goal) begin
			xfer(1'b0, IDX_DUTY_STAT, 8'h00);
			if (rd !== v) begin
				chk(rd, (goal > v) ? v + step : v - step);
				v = rd;
			end
		end
		t = ($time / 10 - t - 8) / tick;
		chk(t >= 240 / step - 2 && t <= 240 / step, 1);
		repeat (2 * tick) @(posedge clk);
		rdk(IDX_DUTY_STAT, goal);
		rdk(IDX_TARGET_STAT, goal);
	endtask

	task ramp(input logic [7:0] flt, input int step, input int tick);
		wr(IDX_FILTER, 8'h80);
		tempLocal <= 8'h00;
		repeat (8) @(posedge clk);
		wr(IDX_FILTER, flt);
		tempLocal <= 8'hC8;
		climb(240, step, tick);
		tempLocal <= 8'h00;
		climb(0, step, tick);
	endtask

	// Hang guard
	initial begin
		repeat (90000) @(posedge clk);
		numErrors++;
		stop_test();
	end

	initial begin
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		tempLocal = 8'h00;
		tempRemote = 8'h00;
		numErrors = 0;
		nChecks = 0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		rdk(IDX_CONFIG, 32'h00000080);
		rdk(IDX_MIN_DUTY, 32'h00000005);
		rdk(IDX_FILTER, 32'h00000010);
		rdk(IDX_LOCAL, 32'h00000043);
		rdk(IDX_REMOTE, 32'h00000063);
		xfer(1'b0, 6'h01, 8'h00);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0);
		wr(IDX_FILTER, 8'h80);
		// Steady-state duty for each row, settings written before the mode
		for (int i = 0; i < 12; i++) begin
			wr(IDX_LOCAL, rows[i][1]);
			wr(IDX_REMOTE, rows[i][2]);
			wr(IDX_CONFIG, rows[i][0]);
			tempLocal  <= rows[i][3];
			tempRemote <= rows[i][4];
			repeat (8) @(posedge clk);
			rdk(IDX_DUTY_STAT, {24'h0, rows[i][5]});
		end
		// Spin-up runs full duty when not suppressed; software mode sets the duty directly
		wr(IDX_CONFIG, 8'h00);
		wr(IDX_FILTER, 8'h00);
		wr(IDX_MIN_DUTY, 8'h00);
		repeat (4) @(posedge clk);
		wr(IDX_MIN_DUTY, 8'h05);
		// Duty lands one cycle after the write and the state machine one more
		repeat (2) @(posedge clk);
		rdk(IDX_DUTY_STAT, 32'h000000F0);
		repeat (12) @(posedge clk);
		rdk(IDX_DUTY_STAT, 32'h00000050);
		repeat (1000) @(posedge clk);
		chk({16'h0, highLen}, 32'd160);
		chk({16'h0, periodLen}, 32'd480);
		wr(IDX_LOCAL, 8'hF8);
		wr(IDX_REMOTE, 8'hF8);
		wr(IDX_CONFIG, 8'hE0);
		tempRemote <= 8'h00;
		for (int k = 0; k < 4; k++) begin
			ramp(8'h9D | 8'(k << 5), 1 << k, 4);
		end
		ramp(8'hF1, 8, 32);
		ramp(8'hE1, 8, 512);
		// Reset in mid-run must bring the filter settings back to their defaults
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rdk(IDX_FILTER, 32'h00000010);
		stop_test();
	end
endmodule
